// >>> dml_debug_message_link.sv
`timescale 1ns/1ps
module dml_debug_message_link
#(
    parameter int NPROC = 1
)
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic warm_reset_i,
    input wire logic tck_i,
    input wire logic tck_reset_i,
    input wire logic tap_update_dr_i,
    input wire logic tap_capture_dr_i,
    input wire logic tap_capture_ir_i,
    input wire dml_pkg::dml_instr_t tap_instr_i,
    input wire logic [dml_pkg::DML_IDW-1:0] tap_ir_pid_i,
    input wire logic [dml_pkg::DML_LENW-1:0] tap_ir_len_i,
    input wire logic [dml_pkg::DML_BUFW-1:0] tap_shift_data_i,
    input wire logic wr_i,
    input wire dml_pkg::dml_wsel_t wr_sel_i,
    input wire logic [dml_pkg::DML_IDXW-1:0] wr_idx_i,
    input wire logic [dml_pkg::DML_WW-1:0] wr_data_i,
    output logic [dml_pkg::DML_BUFW-1:0] rx_buf_o,
    output logic rx_busy_o,
    output logic [dml_pkg::DML_IDW-1:0] rx_pid_o,
    output logic [dml_pkg::DML_LENW-1:0] rx_len_o,
    output logic [dml_pkg::DML_BUFW-1:0] tx_buf_o,
    output logic [dml_pkg::DML_IDW-1:0] tx_pid_o,
    output logic [dml_pkg::DML_LENW-1:0] tx_len_o,
    output logic [dml_pkg::DML_IDW-1:0] tx_lock_pid_o,
    output logic debugger_notify_n_o,
    output logic [NPROC-1:0] src_rx_o,
    output logic [NPROC-1:0] src_abort_o,
    output logic [NPROC-1:0] ise_o,
    output logic chip_reset_o,
    output logic [dml_pkg::DML_BUFW-1:0] tap_capture_data_o,
    output logic [dml_pkg::DML_LENW-1:0] tap_dr_len_o,
    output logic [dml_pkg::DML_IDW+dml_pkg::DML_LENW-1:0] tap_ir_capture_o
);
    import dml_pkg::*;
    // Link clock domain
    logic [3:0] tgl_q;
    logic [DML_WW-1:0] hold_buf_q [DML_WORDS];
    logic [DML_IDW-1:0] hold_pid_q;
    logic [DML_LENW-1:0] hold_len_q;
    logic [NPROC-1:0] mask_tck_q;
    logic nt_s1_q;
    logic nt_s2_q;
    logic [DML_BUFW-1:0] cap_q;
    logic [DML_LENW-1:0] drlen_q;
    logic [DML_IDW+DML_LENW-1:0] ircap_q;
    // Core clock domain
    logic [3:0] ts1_q;
    logic [3:0] ts2_q;
    logic [3:0] ts3_q;
    logic [1:0] arm_q;
    logic [3:0] ev;
    logic ev_rx;
    logic ev_tx;
    logic ev_rst;
    logic ev_mask;
    logic [DML_WW-1:0] rx_buf_q [DML_WORDS];
    logic [DML_WW-1:0] tx_buf_q [DML_WORDS];
    logic rx_busy_q;
    logic [DML_IDW-1:0] rx_pid_q;
    logic [DML_LENW-1:0] rx_len_q;
    logic [DML_IDW-1:0] tx_pid_q;
    logic [DML_LENW-1:0] tx_len_q;
    logic [DML_IDW-1:0] lock_q;
    logic notify_n_q;
    logic warm_clr;
    logic [NPROC-1:0] mask_q;
    logic [NPROC-1:0] src_rx_q;
    logic [NPROC-1:0] src_ab_q;
    logic [NPROC-1:0] src_rx_d;
    logic [NPROC-1:0] src_ab_d;
    logic [NPROC-1:0] ise_q;
    logic chip_rst_q;
    logic [DML_IDW-1:0] lock_wr;
    logic [DML_BUFW-1:0] tx_flat;
    // Each update event toggles its own bit; the held words stay put
    // until the next receive-scan update, which the link takes even while busy is still set.
    always_ff @(posedge tck_i)
    begin
        if (tck_reset_i)
        begin
            tgl_q <= 4'h0;
            mask_tck_q <= '0;
        end
        else if (tap_update_dr_i)
        begin
            unique case (tap_instr_i)
                DML_I_SCAN_RX: tgl_q[0] <= ~tgl_q[0];
                DML_I_SCAN_TX: tgl_q[1] <= ~tgl_q[1];
                DML_I_DBG_RST: tgl_q[2] <= ~tgl_q[2];
                DML_I_MASK:
                begin
                    tgl_q[3] <= ~tgl_q[3];
                    mask_tck_q <= tap_shift_data_i[NPROC-1:0];
                end
                DML_I_OTHER: tgl_q <= tgl_q;
            endcase
        end
    end
    always_ff @(posedge tck_i)
    begin
        if (tap_update_dr_i && tap_instr_i == DML_I_SCAN_RX)
        begin
            for (int i = 0; i < DML_WORDS; i++)
                hold_buf_q[i] <= tap_shift_data_i[i*DML_WW +: DML_WW];
            hold_pid_q <= tap_ir_pid_i;
            hold_len_q <= tap_ir_len_i;
        end
    end
    // Transmit words are only trusted while notify is low: the owner
    // must leave them alone then, so they are static across the crossing.
    always_ff @(posedge tck_i)
    begin
        nt_s1_q <= notify_n_q;
        nt_s2_q <= nt_s1_q;
    end
    always_ff @(posedge tck_i)
    begin
        if (tck_reset_i)
        begin
            cap_q <= '0;
            drlen_q <= DML_LEN_RST;
            ircap_q <= '0;
        end
        else
        begin
            if (tap_instr_i == DML_I_SCAN_RX)
                drlen_q <= tap_ir_len_i;
            else if (tap_instr_i == DML_I_SCAN_TX)
                drlen_q <= nt_s2_q ? DML_LEN_RST : tx_len_q;
            if (tap_capture_dr_i && tap_instr_i == DML_I_SCAN_TX)
                cap_q <= nt_s2_q ? '0 : tx_flat;
            if (tap_capture_ir_i)
                ircap_q <= nt_s2_q ? '0 : {tx_pid_q, tx_len_q};
        end
    end
    // Synchroniser flops are datapath; events are gated until they settle
    always_ff @(posedge core_clk_i)
    begin
        ts1_q <= tgl_q;
        ts2_q <= ts1_q;
        ts3_q <= ts2_q;
    end
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            arm_q <= 2'h0;
        else if (arm_q != 2'h3)
            arm_q <= arm_q + 2'h1;
    end
    assign ev = (arm_q == 2'h3) ? (ts2_q ^ ts3_q) : 4'h0;
    assign ev_rx = ev[0];
    assign ev_tx = ev[1];
    assign ev_rst = ev[2];
    assign ev_mask = ev[3];
    assign warm_clr = warm_reset_i && notify_n_q;
    assign lock_wr = wr_data_i[DML_LOCK_PID_LSB +: DML_IDW];
    always_ff @(posedge core_clk_i)
    begin
        for (int i = 0; i < DML_WORDS; i++)
        begin
            if (ev_rx)
                rx_buf_q[i] <= hold_buf_q[i];
            else if (wr_i && wr_sel_i == DML_W_RXBUF && wr_idx_i == DML_IDXW'(i))
                rx_buf_q[i] <= wr_data_i;
        end
    end
    // Busy set by a new message wins over a clear in the same cycle
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            rx_busy_q <= 1'b0;
            rx_pid_q <= DML_PID_RST;
            rx_len_q <= DML_LEN_RST;
        end
        else
        begin
            if (ev_rx)
            begin
                rx_busy_q <= 1'b1;
                rx_pid_q <= hold_pid_q;
                rx_len_q <= hold_len_q;
            end
            else if (wr_i && wr_sel_i == DML_W_RXST && wr_data_i[DML_RXST_BUSY_BIT])
                rx_busy_q <= 1'b0;
        end
    end
    always_ff @(posedge core_clk_i)
    begin
        for (int i = 0; i < DML_WORDS; i++)
        begin
            if (reset_i)
                tx_buf_q[i] <= DML_WORD_RST;
            else if (wr_i && wr_sel_i == DML_W_TXBUF && wr_idx_i == DML_IDXW'(i))
                tx_buf_q[i] <= wr_data_i;
        end
    end
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i || warm_clr)
        begin
            tx_pid_q <= DML_PID_RST;
            tx_len_q <= DML_LEN_RST;
        end
        else if (wr_i && wr_sel_i == DML_W_TXST)
        begin
            tx_pid_q <= wr_data_i[DML_TXST_PID_LSB +: DML_IDW];
            tx_len_q <= wr_data_i[DML_TXST_LEN_LSB +: DML_LENW];
        end
    end
    // A debugger release in the same cycle as a claim lets the release win
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i || warm_clr)
            lock_q <= DML_PID_FREE;
        else if (ev_tx)
            lock_q <= DML_PID_FREE;
        else if (wr_i && wr_sel_i == DML_W_LOCK)
        begin
            if (lock_wr == DML_PID_FREE && notify_n_q)
                lock_q <= DML_PID_FREE;
            else if (lock_wr != DML_PID_FREE && lock_q == DML_PID_FREE)
                lock_q <= lock_wr;
        end
    end
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            notify_n_q <= 1'b1;
        else if (ev_tx)
            notify_n_q <= 1'b1;
        else if (wr_i && wr_sel_i == DML_W_NOTIFY && wr_data_i[DML_NOTIFY_BIT])
            notify_n_q <= 1'b0;
    end
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            chip_rst_q <= 1'b0;
        else
            chip_rst_q <= ev_rst;
    end
    // Chip reset leaves the mask alone; the copy is refreshed when arm_q reaches DML_ARM_CYC, a cycle before events arm
    always_ff @(posedge core_clk_i)
    begin
        if (arm_q == 2'(DML_ARM_CYC) || ev_mask)
            mask_q <= mask_tck_q;
    end
    always_comb
    begin
        src_rx_d = src_rx_q;
        src_ab_d = src_ab_q;
        if (wr_i && wr_sel_i == DML_W_SRC)
        begin
            src_rx_d = src_rx_q & ~wr_data_i[DML_SRC_RX_LSB +: NPROC];
            src_ab_d = src_ab_q & ~wr_data_i[DML_SRC_AB_LSB +: NPROC];
        end
        for (int i = 0; i < NPROC; i++)
        begin
            if (ev_rx && hold_pid_q == DML_IDW'(i) && hold_pid_q != DML_PID_FREE)
                src_rx_d[i] = 1'b1;
            if (ev_rx && hold_pid_q == DML_PID_FREE && mask_q[i])
                src_ab_d[i] = 1'b1;
            if (wr_i && wr_sel_i == DML_W_ABORT && wr_data_i[i] && mask_q[i])
                src_ab_d[i] = 1'b1;
        end
    end
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            src_rx_q <= '0;
            src_ab_q <= '0;
            ise_q <= '0;
        end
        else
        begin
            src_rx_q <= src_rx_d;
            src_ab_q <= src_ab_d;
            ise_q <= src_rx_d | src_ab_d;
        end
    end
    for (genvar g = 0; g < DML_WORDS; g++)
    begin : g_flat
        assign rx_buf_o[g*DML_WW +: DML_WW] = rx_buf_q[g];
        assign tx_flat[g*DML_WW +: DML_WW] = tx_buf_q[g];
    end
    assign tx_buf_o = tx_flat;
    assign rx_busy_o = rx_busy_q;
    assign rx_pid_o = rx_pid_q;
    assign rx_len_o = rx_len_q;
    assign tx_pid_o = tx_pid_q;
    assign tx_len_o = tx_len_q;
    assign tx_lock_pid_o = lock_q;
    assign debugger_notify_n_o = notify_n_q;
    assign src_rx_o = src_rx_q;
    assign src_abort_o = src_ab_q;
    assign ise_o = ise_q;
    assign chip_reset_o = chip_rst_q;
    assign tap_capture_data_o = cap_q;
    assign tap_dr_len_o = drlen_q;
    assign tap_ir_capture_o = ircap_q;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);
    sequence s_msg;
        ev_rx ##1 rx_busy_q;
    endsequence

    sequence s_release;
        ev_tx ##1 (lock_q == DML_PID_FREE && notify_n_q);
    endsequence
    a_busy_set: assert property (ev_rx |-> s_msg)
        else $error("busy not set by message");
    a_busy_clear: assert property (rx_busy_q && !ev_rx && wr_i && wr_sel_i == DML_W_RXST
        && wr_data_i[DML_RXST_BUSY_BIT] |=> !rx_busy_q)
        else $error("busy not cleared");
    a_lock_held: assert property (wr_i && wr_sel_i == DML_W_LOCK && lock_wr != DML_PID_FREE
        && lock_q != DML_PID_FREE && !ev_tx && !warm_reset_i |=> $stable(lock_q))
        else $error("lock overwritten while owned");
    a_tx_release: assert property (ev_tx && !warm_reset_i |-> s_release)
        else $error("transmit update did not release");
    a_notify_set: assert property (wr_i && wr_sel_i == DML_W_NOTIFY
        && wr_data_i[DML_NOTIFY_BIT] && !ev_tx
        |=> !notify_n_q ##1 (!notify_n_q || $past(ev_tx)))
        else $error("notify not asserted");
    a_warm_keep: assert property (warm_reset_i && !notify_n_q && !ev_tx && !wr_i
        |=> $stable(lock_q) && $stable(tx_len_q))
        else $error("completed message lost on warm reset");
    a_ise_level: assert property (ise_q == (src_rx_q | src_ab_q))
        else $error("interrupt disagrees with sources");
    a_msg_src: assert property (ev_rx && hold_pid_q == DML_PID_RST
        |=> src_rx_q[0] && ise_q[0])
        else $error("message source not raised");
    a_abort_mask: assert property (!mask_q[0] && $stable(mask_q) && !src_ab_q[0]
        |=> !src_ab_q[0])
        else $error("masked abort reached processor");
    a_chip_rst: assert property (ev_rst |=> chip_rst_q ##1 !chip_rst_q)
        else $error("chip reset pulse wrong");
endmodule

// >>> dml_pkg.sv
package dml_pkg;
    localparam int DML_WORDS = 8;
    localparam int DML_WW = 16;
    localparam int DML_IDW = 4;
    localparam int DML_LENW = 4;
    localparam int DML_IDXW = 3;
    localparam int DML_BUFW = DML_WORDS * DML_WW;
    // Free lock value, also the broadcast abort ID of a receive scan
    localparam logic [DML_IDW-1:0] DML_PID_FREE = 4'hF;
    localparam logic [DML_IDW-1:0] DML_PID_RST = 4'h0;
    localparam logic [DML_LENW-1:0] DML_LEN_RST = 4'h0;
    localparam logic [DML_WW-1:0] DML_WORD_RST = 16'h0000;
    localparam int DML_RXST_BUSY_BIT = 0;
    localparam int DML_NOTIFY_BIT = 0;
    localparam int DML_TXST_LEN_LSB = 0;
    localparam int DML_TXST_PID_LSB = 4;
    localparam int DML_LOCK_PID_LSB = 0;
    localparam int DML_SRC_RX_LSB = 0;
    localparam int DML_SRC_AB_LSB = 8;
    localparam int DML_ARM_CYC = 2;

    typedef enum logic [2:0] {
        DML_I_OTHER,
        DML_I_SCAN_RX,
        DML_I_SCAN_TX,
        DML_I_DBG_RST,
        DML_I_MASK
    } dml_instr_t;

    typedef enum logic [2:0] {
        DML_W_RXBUF,
        DML_W_RXST,
        DML_W_TXBUF,
        DML_W_TXST,
        DML_W_LOCK,
        DML_W_NOTIFY,
        DML_W_ABORT,
        DML_W_SRC
    } dml_wsel_t;
endpackage

// >>> dml_tap_model.sv
`timescale 1ns/1ps
module dml_tap_model
(
    output logic tck_o,
    output logic tck_reset_o,
    output logic update_dr_o,
    output logic capture_dr_o,
    output logic capture_ir_o,
    output dml_pkg::dml_instr_t instr_o,
    output logic [dml_pkg::DML_IDW-1:0] pid_o,
    output logic [dml_pkg::DML_LENW-1:0] len_o,
    output logic [dml_pkg::DML_BUFW-1:0] shift_o
);
    import dml_pkg::*;
    initial
    begin
        tck_o = 1'b0;
        tck_reset_o = 1'b1;
        update_dr_o = 1'b0;
        capture_dr_o = 1'b0;
        capture_ir_o = 1'b0;
        instr_o = DML_I_OTHER;
        pid_o = 4'h0;
        len_o = 4'h0;
        shift_o = {8{16'h5A5A}};
    end
    // Link clock only runs inside frames and the two power-up pulses, a debugger parks it between scans
    task automatic pulse();
        #7.5 tck_o = 1'b1;
        #7.5 tck_o = 1'b0;
    endtask
    task automatic power_up();
        pulse();
        pulse();
        tck_reset_o = 1'b0;
    endtask
    // kind 0 update, 1 data capture, 2 instruction capture
    task automatic frame(input int kind, input dml_instr_t ins, input logic [DML_IDW-1:0] processor_id_field,
        input logic [DML_LENW-1:0] len, input logic [DML_BUFW-1:0] data);
        instr_o = ins;
        pid_o = processor_id_field;
        len_o = len;
        shift_o = data;
        // Selection states come first, so the notify synchroniser has settled
        repeat (3) pulse();
        update_dr_o = (kind == 0);
        capture_dr_o = (kind == 1);
        capture_ir_o = (kind == 2);
        pulse();
        update_dr_o = 1'b0;
        capture_dr_o = 1'b0;
        capture_ir_o = 1'b0;
        // Shift path no longer holds the scanned word once the scan is over
        shift_o = ~data;
    endtask
endmodule

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
    import dml_pkg::*;
    localparam logic [DML_BUFW-1:0] RX_PAT = 128'h0123456789ABCDEFFEDCBA9876543210;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic warm = 1'b0;
    logic wr = 1'b0;
    dml_wsel_t sel = DML_W_RXBUF;
    logic [DML_IDXW-1:0] idx = 3'h0;
    logic [DML_WW-1:0] wd = 16'h0000;
    logic tck, trst, upd, cdr, cir, busy, nfy, srx, sab, debug_service_interrupt, crst;
    dml_instr_t ins;
    logic [DML_IDW-1:0] ipid, rxpid, txpid, lpid;
    logic [DML_LENW-1:0] ilen, rxlen, txlen, drlen;
    logic [DML_BUFW-1:0] sdat, rxbuf, txbuf, cap, expbuf;
    logic [DML_IDW+DML_LENW-1:0] ircap;
    int err_count = 0;
    int checked = 0;
    int cyc = 0;
    always #12.5 clk = ~clk;
    dml_tap_model i_tap (.tck_o(tck), .tck_reset_o(trst), .update_dr_o(upd),
        .capture_dr_o(cdr), .capture_ir_o(cir), .instr_o(ins), .pid_o(ipid),
        .len_o(ilen), .shift_o(sdat));
    dml_debug_message_link i_dut (.core_clk_i(clk), .reset_i(rst), .warm_reset_i(warm),
        .tck_i(tck), .tck_reset_i(trst), .tap_update_dr_i(upd), .tap_capture_dr_i(cdr),
        .tap_capture_ir_i(cir), .tap_instr_i(ins), .tap_ir_pid_i(ipid), .tap_ir_len_i(ilen),
        .tap_shift_data_i(sdat), .wr_i(wr), .wr_sel_i(sel), .wr_idx_i(idx), .wr_data_i(wd),
        .rx_buf_o(rxbuf), .rx_busy_o(busy), .rx_pid_o(rxpid), .rx_len_o(rxlen),
        .tx_buf_o(txbuf), .tx_pid_o(txpid), .tx_len_o(txlen), .tx_lock_pid_o(lpid),
        .debugger_notify_n_o(nfy), .src_rx_o(srx), .src_abort_o(sab), .ise_o(debug_service_interrupt),
        .chip_reset_o(crst), .tap_capture_data_o(cap), .tap_dr_len_o(drlen),
        .tap_ir_capture_o(ircap));
    task automatic finish_test();
        if (err_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [DML_BUFW-1:0] got, input logic [DML_BUFW-1:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic put(input dml_wsel_t s, input logic [DML_IDXW-1:0] i,
        input logic [DML_WW-1:0] d);
        @(posedge clk);
        wr <= 1'b1;
        sel <= s;
        idx <= i;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic warm_pulse();
        @(posedge clk);
        warm <= 1'b1;
        repeat (2) @(posedge clk);
        warm <= 1'b0;
        cycles(1);
    endtask
    // Crossing latency is two to three core cycles, so six leaves margin
    task automatic upd_frame(input dml_instr_t i, input logic [DML_IDW-1:0] p,
        input logic [DML_BUFW-1:0] d);
        i_tap.frame(0, i, p, 4'h5, d);
        cycles(6);
    endtask
    task automatic t_reset();
        chk(busy, 1'b0);
        chk({rxpid, rxlen, txpid, txlen}, 16'h0000);
        chk(txbuf, '0);
        chk(lpid, DML_PID_FREE);
        chk(nfy, 1'b1);
        chk({srx, sab, debug_service_interrupt, crst}, 4'h0);
    endtask
    task automatic t_rx();
        upd_frame(DML_I_SCAN_RX, 4'h0, RX_PAT);
        chk({busy, rxpid, rxlen}, 9'h105);
        chk(rxbuf, RX_PAT);
        chk(drlen, 4'h5);
        chk({srx, debug_service_interrupt}, 2'h3);
        put(DML_W_RXST, 3'h0, 16'h0000);
        chk(busy, 1'b1);
        put(DML_W_RXST, 3'h0, 16'h0001);
        chk(busy, 1'b0);
        chk(rxbuf, RX_PAT);
        put(DML_W_SRC, 3'h0, 16'h0000);
        chk(srx, 1'b1);
        put(DML_W_SRC, 3'h0, 16'h0001);
        chk({srx, debug_service_interrupt}, 2'h0);
    endtask
    task automatic t_lock();
        put(DML_W_LOCK, 3'h0, 16'h0000);
        chk(lpid, 4'h0);
        put(DML_W_LOCK, 3'h0, 16'h0003);
        chk(lpid, 4'h0);
        put(DML_W_LOCK, 3'h0, 16'h000F);
        chk(lpid, DML_PID_FREE);
        put(DML_W_LOCK, 3'h0, 16'h0003);
        chk(lpid, 4'h3);
        put(DML_W_LOCK, 3'h0, 16'h000F);
    endtask
    task automatic t_tx();
        put(DML_W_LOCK, 3'h0, 16'h0000);
        for (int i = 0; i < DML_WORDS; i++)
        begin
            put(DML_W_TXBUF, DML_IDXW'(i), 16'hA000 + 16'(i));
            expbuf[i*DML_WW +: DML_WW] = 16'hA000 + 16'(i);
        end
        put(DML_W_TXST, 3'h0, 16'h0008);
        chk(txbuf, expbuf);
        chk({txpid, txlen}, 8'h08);
        put(DML_W_NOTIFY, 3'h0, 16'h0001);
        chk(nfy, 1'b0);
        put(DML_W_LOCK, 3'h0, 16'h000F);
        chk(lpid, 4'h0);
        warm_pulse();
        chk({lpid, txpid, txlen}, 12'h008);
        i_tap.frame(2, DML_I_SCAN_TX, 4'h0, 4'h0, '0);
        chk(ircap, 8'h08);
        i_tap.frame(1, DML_I_SCAN_TX, 4'h0, 4'h0, '0);
        chk(cap, expbuf);
        chk(drlen, 4'h8);
        upd_frame(DML_I_SCAN_TX, 4'h0, '0);
        chk({lpid, nfy}, {DML_PID_FREE, 1'b1});
        put(DML_W_LOCK, 3'h0, 16'h0002);
        put(DML_W_TXST, 3'h0, 16'h0025);
        warm_pulse();
        chk({lpid, txpid, txlen}, 12'hF00);
    endtask
    task automatic t_abort();
        upd_frame(DML_I_MASK, 4'h0, '0);
        put(DML_W_ABORT, 3'h0, 16'h0001);
        chk({sab, debug_service_interrupt}, 2'h0);
        upd_frame(DML_I_MASK, 4'h0, 128'h1);
        put(DML_W_ABORT, 3'h0, 16'h0000);
        chk({sab, debug_service_interrupt}, 2'h0);
        put(DML_W_ABORT, 3'h0, 16'h0001);
        chk({sab, debug_service_interrupt}, 2'h3);
        put(DML_W_SRC, 3'h0, 16'h0100);
        chk({sab, debug_service_interrupt}, 2'h0);
        upd_frame(DML_I_SCAN_RX, DML_PID_FREE, RX_PAT);
        chk({srx, sab, debug_service_interrupt}, 3'h3);
        upd_frame(DML_I_SCAN_RX, 4'h0, RX_PAT);
        chk({srx, sab, debug_service_interrupt}, 3'h7);
        put(DML_W_SRC, 3'h0, 16'h0100);
        chk({srx, sab, debug_service_interrupt}, 3'h5);
        put(DML_W_SRC, 3'h0, 16'h0001);
        chk({srx, debug_service_interrupt}, 2'h0);
    endtask
    task automatic t_chip();
        int n;
        n = 0;
        i_tap.frame(0, DML_I_DBG_RST, 4'h0, 4'h0, '0);
        repeat (10)
        begin
            cycles(1);
            if (crst === 1'b1)
                n++;
        end
        chk(n, 1);
    endtask
    task automatic t_final();
        put(DML_W_SRC, 3'h0, 16'h0000);
        upd_frame(DML_I_SCAN_RX, 4'h0, RX_PAT);
        @(posedge clk);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        cycles(1);
        chk({busy, rxpid, rxlen}, 9'h000);
        chk(rxbuf, RX_PAT);
        chk({srx, sab, debug_service_interrupt}, 3'h0);
        chk({lpid, nfy}, {DML_PID_FREE, 1'b1});
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_count++;
            finish_test();
        end
    end
    initial
    begin
        i_tap.power_up();
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        cycles(5);
        t_reset();
        t_rx();
        t_lock();
        t_tx();
        t_abort();
        t_chip();
        t_final();
        finish_test();
    end
endmodule
